/* File: rtl/embc_ctrl.sv */
// External memory bus controller: regions, strobes, mux modes and bursts
// How it works
// R1: Control bit picks an 8-bit or 16-bit data path at run time.
// R2: Four regions, each with its own active-low select output.
// R3: Each region holds separate read and write wait counts stretching strobes.
// R4: Static async reads and writes; page mode reads when non-multiplexed.
// R5: One active-low read strobe covers both bytes in every width.
// R6: Low write strobe is the only write strobe in 8-bit mode.
// R7: High write strobe qualifies upper byte writes in 16-bit mode only.
// R8: Multiplexed modes drive an address latch strobe of programmable polarity.
// R9: 16-bit mux: ports 8/9 share address 15..0 and data; port 7 high.
// R10: 8-bit mux: 24 address bits, low byte shared with data on port 8.
// R11: 8-bit mux: port 9 address then zeros on writes, ignored on reads.
// R12: 8-bit mux: port 7 drives top address byte for the whole access.
// R13: Far side latches mid address bits with the latch strobe.
// R14: 8-bit non-mux: port 8 data, ports 7 and 9 carry 16 address bits.
// R15: Synchronous burst reads and writes in mux and non-mux modes.
// R16: Burst clock runs at full or half rate, or can be switched off.
// R17: Active-low wait input stalls synchronous beats while asserted.
// R18: Bursts drive active-low advance/enable and a dedicated write enable.
// R19: Byte write strobe pins can become upper and lower byte enables.
// R20: Burst length, type and latency come from control fields.
// R21: Exactly the select of the addressed region is active during access.
// R22: Only needed byte strobes assert; read and write strobes never together unless byte enables are on.
`timescale 1ns/1ps
`include "embc_consts.svh"
module embc_ctrl (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire embc_pkg::embc_reg_addr_t reg_addr,
  input wire embc_pkg::embc_data_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output embc_pkg::embc_data_t reg_rdata,
  input wire logic req_valid,
  input wire logic req_write,
  input wire embc_pkg::embc_addr_t req_addr,
  input wire embc_pkg::embc_data_t req_wdata,
  input wire logic [1:0] req_be,
  output logic req_ready,
  output logic resp_valid,
  output embc_pkg::embc_data_t resp_rdata,
  output logic [7:0] port7_out,
  output logic [7:0] port8_out,
  input wire logic [7:0] port8_in,
  output logic port8_oe_n,
  output logic [7:0] port9_out,
  input wire logic [7:0] port9_in,
  output logic port9_oe_n,
  output logic read_strobe_n,
  output logic write_low_strobe_n,
  output logic write_high_strobe_n,
  output logic addr_latch_strobe,
  output logic region0_select_n,
  output logic region1_select_n,
  output logic region2_select_n,
  output logic region3_select_n,
  output logic burst_bus_clock,
  input wire logic wait_input_n,
  output logic burst_advance_n,
  output logic burst_write_enable_n
);
  import embc_pkg::*;

  logic [15:0] ctrl;
  logic [7:0] region_cfg [4];
  logic [3:0] burst_cfg;
  logic cfg_w16, cfg_mux, cfg_ale_pol, cfg_byte_en, cfg_wrap, cfg_page;
  logic cfg_div2, cfg_bclk_en, burst_mode;
  logic [1:0] cfg_blen;
  logic wait_s1, wait_s2;
  logic [15:0] in_s1, in_s2;
  embc_state_e state;
  logic cur_write, cur_burst;
  logic [1:0] cur_be;
  embc_addr_t cur_addr, baddr, next_baddr;
  embc_data_t wdata_reg;
  logic [3:0] wcnt, lcnt, bcnt, blen_beats;
  logic [1:0] cur_region, req_region;
  logic [3:0] cur_rwait, cur_wwait, cur_wait;
  logic page_valid, page_hit;
  logic [20:0] page_addr;
  logic [1:0] rd_pipe;
  logic half_cnt, bclk_tick, beat_go, last_beat;
  logic [7:0] step8, mask8;
  logic [3:0] sel_n;
  logic [3:0] next_sel_n;
  logic [7:0] next_p7, next_p8, next_p9;
  logic next_p8_oe_n, next_p9_oe_n, next_rd_n, next_wl_n, next_wh_n;
  logic next_ale, next_bav_n, next_bwe_n;
  logic active, mux_addr_phase, strobe_phase;

  assign cfg_w16 = ctrl[`EMBC_CTRL_WIDTH16];
  assign cfg_mux = ctrl[`EMBC_CTRL_MUX];
  assign cfg_ale_pol = ctrl[`EMBC_CTRL_ALE_POL];
  assign cfg_byte_en = ctrl[`EMBC_CTRL_BYTE_EN];
  assign cfg_div2 = ctrl[`EMBC_CTRL_BCLK_DIV2];
  assign cfg_bclk_en = ctrl[`EMBC_CTRL_BCLK_EN];
  assign cfg_blen = ctrl[`EMBC_CTRL_BLEN_HI:`EMBC_CTRL_BLEN_LO];
  assign cfg_wrap = ctrl[`EMBC_CTRL_WRAP];
  assign cfg_page = ctrl[`EMBC_CTRL_PAGE];
  // Bursts need the bus clock running
  assign burst_mode = ctrl[`EMBC_CTRL_BURST] & cfg_bclk_en; // see R15

  // Register writes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `EMBC_CTRL_RESET;
      burst_cfg <= `EMBC_BURST_RESET;
    end else if (reg_wr) begin
      if (reg_addr == `EMBC_REG_CTRL) begin
        ctrl <= reg_wdata; // see R1
      end else if (reg_addr == `EMBC_REG_BURST) begin
        burst_cfg <= reg_wdata[3:0]; // see R20
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_region
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          region_cfg[gi] <= `EMBC_REGION_RESET;
        end else if (reg_wr && reg_addr == `EMBC_REG_REGION0 + 4'(gi)) begin
          region_cfg[gi] <= reg_wdata[7:0]; // see R3
        end
      end
    end
  endgenerate

  // Register reads, data in the following cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      if (reg_addr == `EMBC_REG_CTRL) begin
        reg_rdata <= ctrl;
      end else if (reg_addr >= `EMBC_REG_REGION0 &&
                   reg_addr < `EMBC_REG_STATUS) begin
        reg_rdata <= {8'h00, region_cfg[2'(reg_addr - `EMBC_REG_REGION0)]};
      end else if (reg_addr == `EMBC_REG_STATUS) begin
        reg_rdata <= {4'h0, bcnt, 3'h0, page_valid, wait_s2, cur_region,
                      state != EMBC_IDLE};
      end else if (reg_addr == `EMBC_REG_BURST) begin
        reg_rdata <= {12'h000, burst_cfg};
      end else begin
        reg_rdata <= 16'h0000;
      end
    end
  end

  // Pin input synchronisers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_s1 <= 1'b1;
      wait_s2 <= 1'b1;
      in_s1 <= 16'h0000;
      in_s2 <= 16'h0000;
    end else begin
      wait_s1 <= wait_input_n;
      wait_s2 <= wait_s1;
      in_s1 <= {port9_in, port8_in};
      in_s2 <= in_s1;
    end
  end

  // Burst bus clock divider
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      burst_bus_clock <= 1'b0;
      half_cnt <= 1'b0;
    end else if (!cfg_bclk_en) begin
      burst_bus_clock <= 1'b0; // see R16
      half_cnt <= 1'b0;
    end else begin
      half_cnt <= ~half_cnt;
      if (!cfg_div2 || half_cnt) begin
        burst_bus_clock <= ~burst_bus_clock; // see R16
      end
    end
  end
  // Cycle just before a rising burst clock edge
  assign bclk_tick = cfg_bclk_en & ~burst_bus_clock & (~cfg_div2 | half_cnt);

  assign cur_region = cur_addr[`EMBC_REGION_MSB:`EMBC_REGION_LSB];
  assign req_region = req_addr[`EMBC_REGION_MSB:`EMBC_REGION_LSB];
  assign cur_rwait = region_cfg[cur_region][`EMBC_RWAIT_HI:`EMBC_RWAIT_LO];
  assign cur_wwait = region_cfg[cur_region][`EMBC_WWAIT_HI:`EMBC_WWAIT_LO];
  assign cur_wait = cur_write ? cur_wwait : cur_rwait; // see R3
  assign blen_beats = 4'h1 << cfg_blen; // see R20
  assign last_beat = (bcnt == blen_beats - 4'h1);
  assign step8 = cfg_w16 ? 8'h02 : 8'h01;
  assign mask8 = 8'(({4'h0, blen_beats} << cfg_w16) - 8'h01);
  always_comb begin
    if (cfg_wrap) begin
      next_baddr = {baddr[23:8],
                    (baddr[7:0] & ~mask8) | (8'(baddr[7:0] + step8) & mask8)};
    end else begin
      next_baddr = 24'(baddr + {16'h0000, step8});
    end
  end
  // Beat needs bus ready and, for writes, the next data word
  assign beat_go = (state == EMBC_BURST) && bclk_tick && wait_s2 &&
                   (!cur_write || last_beat || req_valid); // see R17
  assign page_hit = page_valid && cfg_page && !cfg_mux && !req_write &&
                    req_addr[23:`EMBC_PAGE_LSB] == page_addr; // see R4
  assign req_ready = (state == EMBC_IDLE) ||
                     (beat_go && cur_write && !last_beat);

  // Access sequencer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= EMBC_IDLE;
      cur_write <= 1'b0;
      cur_burst <= 1'b0;
      cur_addr <= 24'h000000;
      baddr <= 24'h000000;
      wcnt <= 4'h0;
      lcnt <= 4'h0;
      bcnt <= 4'h0;
    end else begin
      case (state)
        EMBC_IDLE: begin
          if (req_valid) begin
            cur_write <= req_write;
            cur_addr <= req_addr;
            cur_burst <= burst_mode;
            baddr <= req_addr;
            bcnt <= 4'h0;
            lcnt <= burst_cfg;
            if (burst_mode) begin
              state <= EMBC_ADDR; // see R15
            end else if (page_hit) begin
              wcnt <= region_cfg[req_region][`EMBC_RWAIT_HI:`EMBC_RWAIT_LO];
              state <= EMBC_STROBE; // see R4
            end else begin
              state <= EMBC_ADDR;
            end
          end
        end
        EMBC_ADDR: begin
          if (!cur_burst) begin
            wcnt <= cur_wait;
            state <= EMBC_STROBE;
          end else if (bclk_tick) begin
            if (lcnt == 4'h0) begin
              state <= EMBC_BURST; // see R20
            end else begin
              lcnt <= lcnt - 4'h1;
            end
          end
        end
        EMBC_STROBE: begin
          if (wcnt == 4'h0) begin
            state <= EMBC_HOLD;
          end else begin
            wcnt <= wcnt - 4'h1; // see R3
          end
        end
        EMBC_BURST: begin
          if (beat_go) begin
            bcnt <= bcnt + 4'h1;
            baddr <= next_baddr;
            if (last_beat) begin
              state <= EMBC_HOLD;
            end
          end
        end
        EMBC_HOLD: state <= EMBC_DONE;
        EMBC_DONE: state <= EMBC_IDLE;
        default: state <= EMBC_IDLE;
      endcase
    end
  end

  // Write data and byte lanes for the current beat
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdata_reg <= 16'h0000;
      cur_be <= 2'b00;
    end else if ((state == EMBC_IDLE && req_valid) ||
                 (beat_go && cur_write && !last_beat)) begin
      wdata_reg <= req_wdata;
      cur_be <= cfg_w16 ? req_be : 2'b01;
    end
  end

  // Open page tracking
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      page_valid <= 1'b0;
      page_addr <= 21'h00000;
    end else if (reg_wr && reg_addr == `EMBC_REG_CTRL) begin
      page_valid <= 1'b0;
    end else if (state == EMBC_DONE && !cur_write && !cur_burst) begin
      page_valid <= cfg_page && !cfg_mux;
      page_addr <= cur_addr[23:`EMBC_PAGE_LSB];
    end else if (state == EMBC_IDLE && req_valid && !page_hit) begin
      page_valid <= 1'b0;
    end
  end

  // Read returns, two cycles behind the pins
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_pipe <= 2'b00;
      resp_valid <= 1'b0;
      resp_rdata <= 16'h0000;
    end else begin
      rd_pipe <= {rd_pipe[0], beat_go & ~cur_write};
      resp_valid <= (state == EMBC_DONE && !cur_write && !cur_burst) ||
                    rd_pipe[1];
      if ((state == EMBC_DONE && !cur_write && !cur_burst) || rd_pipe[1]) begin
        resp_rdata <= cfg_w16 ? in_s2 : {8'h00, in_s2[7:0]}; // see R11
      end
    end
  end

  // Pin values for the coming cycle
  always_comb begin
    active = state != EMBC_IDLE && state != EMBC_DONE;
    mux_addr_phase = cfg_mux && state == EMBC_ADDR;
    strobe_phase = state == EMBC_STROBE || state == EMBC_BURST;
    next_sel_n = 4'hf;
    next_p7 = cur_addr[23:16];
    next_p8 = 8'h00;
    next_p9 = 8'h00;
    next_p8_oe_n = 1'b1;
    next_p9_oe_n = 1'b1;
    next_rd_n = 1'b1;
    next_wl_n = 1'b1;
    next_wh_n = 1'b1;
    next_ale = ~cfg_ale_pol;
    next_bav_n = 1'b1;
    next_bwe_n = 1'b1;
    if (active) begin
      next_sel_n[cur_region] = 1'b0; // see R21
      if (mux_addr_phase) begin
        next_p8 = baddr[7:0]; // see R9
        next_p9 = baddr[15:8]; // see R10
        next_p8_oe_n = 1'b0;
        next_p9_oe_n = 1'b0;
        next_ale = cfg_ale_pol; // see R8
      end else begin
        if (!cfg_mux) begin
          next_p7 = baddr[7:0]; // see R14
        end
        if (cur_write) begin
          next_p8 = wdata_reg[7:0];
          next_p8_oe_n = 1'b0;
        end
        if (!cfg_w16 && !cfg_mux) begin
          next_p9 = baddr[15:8]; // see R14
          next_p9_oe_n = 1'b0;
        end else if (cur_write) begin
          // 8-bit mux writes hold port 9 at zero
          next_p9 = cfg_w16 ? wdata_reg[15:8] : 8'h00; // see R11
          next_p9_oe_n = 1'b0;
        end
      end
      if (cfg_byte_en) begin
        next_wl_n = ~cur_be[0]; // see R19
        next_wh_n = ~(cur_be[1] & cfg_w16);
      end
      if (cur_burst) begin
        next_bav_n = 1'b0; // see R18
      end
    end
    if (strobe_phase) begin
      if (!cur_write) begin
        next_rd_n = 1'b0; // see R5
      end else if (cfg_byte_en || cur_burst) begin
        next_bwe_n = 1'b0; // see R18
      end
      if (cur_write && !cfg_byte_en) begin
        next_wl_n = ~cur_be[0]; // see R6
        next_wh_n = ~(cur_be[1] & cfg_w16); // see R7
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_n <= 4'hf;
      port7_out <= 8'h00;
      port8_out <= 8'h00;
      port9_out <= 8'h00;
      port8_oe_n <= 1'b1;
      port9_oe_n <= 1'b1;
      read_strobe_n <= 1'b1;
      write_low_strobe_n <= 1'b1;
      write_high_strobe_n <= 1'b1;
      addr_latch_strobe <= 1'b0;
      burst_advance_n <= 1'b1;
      burst_write_enable_n <= 1'b1;
    end else begin
      sel_n <= next_sel_n; // see R2
      port7_out <= next_p7; // see R12
      port8_out <= next_p8;
      port9_out <= next_p9;
      port8_oe_n <= next_p8_oe_n;
      port9_oe_n <= next_p9_oe_n;
      read_strobe_n <= next_rd_n;
      write_low_strobe_n <= next_wl_n;
      write_high_strobe_n <= next_wh_n;
      addr_latch_strobe <= next_ale;
      burst_advance_n <= next_bav_n;
      burst_write_enable_n <= next_bwe_n;
    end
  end
  assign region0_select_n = sel_n[0];
  assign region1_select_n = sel_n[1];
  assign region2_select_n = sel_n[2];
  assign region3_select_n = sel_n[3];

  // Strobe cycle counter for checking
  logic [4:0] scnt;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scnt <= 5'h00;
    end else if (state == EMBC_STROBE) begin
      scnt <= scnt + 5'h01;
    end else if (state == EMBC_IDLE) begin
      scnt <= 5'h00;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_one_select: assert property ($onehot0(~sel_n)) // see R21
    else $error("more than one region select active");
  a_select_region: assert property ( // see R2
    (sel_n != 4'hf) |-> !sel_n[cur_region])
    else $error("wrong region select active");
  a_strobe_len: assert property ( // see R3
    (state == EMBC_HOLD && !cur_burst) |-> scnt == {1'b0, cur_wait} + 5'h01)
    else $error("strobe length differs from wait count");
  a_no_rd_wr: assert property ( // see R22
    !cfg_byte_en |-> !(!read_strobe_n &&
      (!write_low_strobe_n || !write_high_strobe_n || !burst_write_enable_n)))
    else $error("read and write strobes together");
  a_high_8bit: assert property ((!cfg_w16 && !cfg_byte_en) |-> // see R7
    write_high_strobe_n)
    else $error("high write strobe in 8-bit mode");
  a_ale_mux: assert property ((addr_latch_strobe == cfg_ale_pol) |-> // see R8
    cfg_mux)
    else $error("latch strobe outside multiplexed mode");
  a_p9_zero: assert property ( // see R11
    (cfg_mux && !cfg_w16 && !cfg_byte_en && !write_low_strobe_n) |->
      (port9_out == 8'h00 && !port9_oe_n))
    else $error("port 9 not zero in 8-bit mux write");
  a_p7_high: assert property ((cfg_mux && sel_n != 4'hf) |-> // see R12
    port7_out == cur_addr[23:16])
    else $error("port 7 lost the high address byte");
  a_bclk_off: assert property (!cfg_bclk_en |=> !burst_bus_clock) // see R16
    else $error("burst clock runs while disabled");
  a_bclk_full: assert property ( // see R16
    (cfg_bclk_en && !cfg_div2) ##1 (cfg_bclk_en && !cfg_div2) |->
      burst_bus_clock != $past(burst_bus_clock))
    else $error("burst clock not toggling at full rate");
  a_wait_holds: assert property ( // see R17
    (state == EMBC_BURST && bclk_tick && !wait_s2) |=>
      ($stable(bcnt) && state == EMBC_BURST))
    else $error("beat advanced while wait asserted");
  a_burst_adv: assert property (!burst_advance_n |-> cur_burst) // see R18
    else $error("advance asserted outside a burst");
endmodule

/* File: rtl/embc_consts.svh */
// Register offsets, field positions and reset values of the memory bus ctrl
`ifndef EMBC_CONSTS_SVH
`define EMBC_CONSTS_SVH
`define EMBC_REG_CTRL 4'h0
`define EMBC_REG_REGION0 4'h1
`define EMBC_REG_STATUS 4'h5
`define EMBC_REG_BURST 4'h6
`define EMBC_CTRL_WIDTH16 0
`define EMBC_CTRL_MUX 1
`define EMBC_CTRL_ALE_POL 2
`define EMBC_CTRL_BYTE_EN 3
`define EMBC_CTRL_BURST 4
`define EMBC_CTRL_BCLK_DIV2 5
`define EMBC_CTRL_BCLK_EN 6
`define EMBC_CTRL_BLEN_LO 8
`define EMBC_CTRL_BLEN_HI 9
`define EMBC_CTRL_WRAP 10
`define EMBC_CTRL_PAGE 11
`define EMBC_CTRL_RESET 16'h0004
`define EMBC_RWAIT_LO 0
`define EMBC_RWAIT_HI 3
`define EMBC_WWAIT_LO 4
`define EMBC_WWAIT_HI 7
`define EMBC_REGION_RESET 8'hff
`define EMBC_BURST_RESET 4'h1
`define EMBC_REGION_MSB 23
`define EMBC_REGION_LSB 22
`define EMBC_PAGE_LSB 3
`endif

/* File: rtl/embc_pkg.sv */
// Types shared by the external memory bus controller
package embc_pkg;
  typedef enum logic [5:0] {
    EMBC_IDLE = 6'h01,
    EMBC_ADDR = 6'h02,
    EMBC_STROBE = 6'h04,
    EMBC_HOLD = 6'h08,
    EMBC_DONE = 6'h10,
    EMBC_BURST = 6'h20
  } embc_state_e;
  typedef logic [23:0] embc_addr_t;
  typedef logic [15:0] embc_data_t;
  typedef logic [3:0] embc_reg_addr_t;
endpackage

/* File: testbench/embc_mem_model.sv */
// Behavioural external memory with one word per region
`timescale 1ns/1ps
module embc_mem_model (
  input wire logic sys_clk,
  input wire logic [3:0] sel_n,
  input wire logic read_strobe_n,
  input wire logic write_low_strobe_n,
  input wire logic write_high_strobe_n,
  input wire logic [7:0] port8_out,
  input wire logic [7:0] port9_out,
  input wire logic port8_oe_n,
  input wire logic stall,
  output logic [7:0] port8_in,
  output logic [7:0] port9_in,
  output logic wait_input_n
);
  logic [15:0] mem [4];
  logic [15:0] last;
  logic [1:0] r;
  logic act;
  initial begin
    mem = '{16'h0, 16'h0, 16'h0, 16'h0};
    last = 16'h0;
  end
  assign act = (sel_n != 4'hf);
  assign r = !sel_n[0] ? 2'h0 : !sel_n[1] ? 2'h1 : !sel_n[2] ? 2'h2 : 2'h3;
  always @(posedge sys_clk) begin
    if (act && !port8_oe_n && !write_low_strobe_n)
      mem[r][7:0] <= port8_out;
    if (act && !port8_oe_n && !write_high_strobe_n)
      mem[r][15:8] <= port9_out;
    if (act && !read_strobe_n)
      last <= mem[r];
  end
  // Released bus shows the inverse of the last word
  always_comb begin
    port8_in = (act && !read_strobe_n) ? mem[r][7:0] : ~last[7:0];
    port9_in = (act && !read_strobe_n) ? mem[r][15:8] : ~last[15:8];
  end
  assign wait_input_n = !stall;
endmodule

/* File: testbench/external_memory_bus_ctrl_test.sv */
// Self-checking bench for the external memory bus controller
`timescale 1ns/1ps
`include "embc_consts.svh"
module external_memory_bus_ctrl_test;
  import embc_pkg::*;
  logic sys_clk = 0;
  logic rst_n = 0;
  embc_reg_addr_t reg_addr = '0;
  embc_data_t reg_wdata = '0;
  embc_data_t req_wdata = '0;
  embc_data_t reg_rdata, resp_rdata;
  logic reg_wr = 0, reg_rd = 0, req_valid = 0, req_write = 0, stall = 0;
  embc_addr_t req_addr = '0;
  logic [1:0] req_be = 2'h3;
  logic req_ready, resp_valid, p8_oe_n, p9_oe_n, rs_n, wl_n, wh_n, ale;
  logic bclk, wait_n, adv_n, bwe_n;
  logic [7:0] p7, p8o, p8i, p9o, p9i;
  wire [3:0] sel_n;
  int fail_count = 0, comparisons = 0, cycles = 0;
  int rd_len, wr_len, rd_cnt = 0, wr_cnt = 0, hi_cnt, lo_cnt;
  int multi = 0, clash = 0, tgl, adv, we;
  logic idle_prev = 1, ale_first, last_bclk = 0;
  logic [3:0] sel_seen;
  logic [7:0] p7_seen, p9_seen, p9_wr;

  embc_ctrl DUT (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_be(req_be),
    .req_ready(req_ready), .resp_valid(resp_valid), .resp_rdata(resp_rdata),
    .port7_out(p7), .port8_out(p8o), .port8_in(p8i), .port8_oe_n(p8_oe_n),
    .port9_out(p9o), .port9_in(p9i), .port9_oe_n(p9_oe_n),
    .read_strobe_n(rs_n), .write_low_strobe_n(wl_n),
    .write_high_strobe_n(wh_n), .addr_latch_strobe(ale),
    .region0_select_n(sel_n[0]), .region1_select_n(sel_n[1]),
    .region2_select_n(sel_n[2]), .region3_select_n(sel_n[3]),
    .burst_bus_clock(bclk), .wait_input_n(wait_n),
    .burst_advance_n(adv_n), .burst_write_enable_n(bwe_n));

  embc_mem_model mem (.sys_clk(sys_clk), .sel_n(sel_n), .read_strobe_n(rs_n),
    .write_low_strobe_n(wl_n), .write_high_strobe_n(wh_n),
    .port8_out(p8o), .port9_out(p9o), .port8_oe_n(p8_oe_n), .stall(stall),
    .port8_in(p8i), .port9_in(p9i), .wait_input_n(wait_n));

  always #5 sys_clk = ~sys_clk;

  // Pin monitor: strobe lengths and address phase snapshot
  always @(posedge sys_clk) if (rst_n) begin
    if ($countones(~sel_n) > 1) multi++;
    if (!rs_n && !(wl_n && wh_n)) clash++;
    if (!wh_n) hi_cnt++;
    if (!wl_n) lo_cnt++;
    if (!rs_n) rd_cnt++;
    else if (rd_cnt > 0) begin
      rd_len = rd_cnt;
      rd_cnt = 0;
    end
    if (!wl_n || !wh_n) begin
      wr_cnt++;
      p9_wr = p9o;
    end else if (wr_cnt > 0) begin
      wr_len = wr_cnt;
      wr_cnt = 0;
    end
    if (bclk != last_bclk) tgl++;
    last_bclk = bclk;
    if (!adv_n) adv++;
    if (!bwe_n) we++;
    if (sel_n != 4'hf && idle_prev) begin
      ale_first = ale;
      sel_seen = sel_n;
      p7_seen = p7;
      p9_seen = p9o;
    end
    idle_prev = (sel_n == 4'hf);
  end

  task automatic close_out;
    $display("Compared %0d values, %0d mismatches", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      close_out();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_write(input embc_reg_addr_t a, input embc_data_t d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge sys_clk);
    reg_wr <= 0;
  endtask

  task automatic reg_read(input embc_reg_addr_t a, output embc_data_t d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge sys_clk);
    reg_rd <= 0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask

  // One access; waits for the answer or the return to idle
  task automatic mem_xfer(input logic wr, input embc_addr_t a,
      input embc_data_t d, input logic [1:0] be, output embc_data_t q,
      output int lat);
    int n;
    hi_cnt = 0;
    lo_cnt = 0;
    tgl = 0;
    adv = 0;
    we = 0;
    @(posedge sys_clk);
    req_valid <= 1;
    req_write <= wr;
    req_addr <= a;
    req_wdata <= d;
    req_be <= be;
    do @(negedge sys_clk); while (req_ready !== 1'b1);
    @(posedge sys_clk);
    req_valid <= 0;
    for (n = 0; n < 200; n++) begin
      @(negedge sys_clk);
      if (wr ? (req_ready === 1'b1 && sel_n === 4'hf) : resp_valid === 1'b1)
        break;
    end
    lat = n;
    q = resp_rdata;
    check({15'h0, n < 200}, 16'h1);
  endtask

  initial begin
    embc_data_t q;
    embc_addr_t a;
    int lat;
    int r;
    repeat (6) @(posedge sys_clk);
    check({9'h0, rs_n, wl_n, wh_n, sel_n}, 16'h007f);
    rst_n <= 1;
    reg_read(`EMBC_REG_CTRL, q);
    check(q, `EMBC_CTRL_RESET);
    reg_read(`EMBC_REG_REGION0, q);
    check(q, 16'h00ff);
    reg_read(`EMBC_REG_BURST, q);
    check(q, 16'h0001);
    reg_write(4'hf, 16'h1234);
    reg_read(4'hf, q);
    check(q, 16'h0000);
    for (r = 0; r < 4; r++) reg_write(4'(r + 1), r == 2 ? 16'h0025 : 16'h0013);
    reg_write(`EMBC_REG_CTRL, 16'h0007);
    for (r = 0; r < 4; r++) begin
      a = {r[1:0], 6'h05, 8'h12, 8'(r)};
      mem_xfer(1, a, 16'ha500 | 16'(r), 2'h3, q, lat);
      check({12'h0, sel_seen}, {12'h0, ~(4'h1 << r)});
      check({p7_seen, p9_seen}, a[23:8]);
      check({15'h0, ale_first}, 16'h1);
      check(16'(wr_len), r == 2 ? 16'h3 : 16'h2);
      check({15'h0, hi_cnt != 0}, 16'h1);
      mem_xfer(0, a, 16'h0, 2'h3, q, lat);
      check(q, 16'ha500 | 16'(r));
      check(16'(rd_len), r == 2 ? 16'h6 : 16'h4);
    end
    mem_xfer(1, 24'h000020, 16'h3377, 2'h1, q, lat);
    check(16'(hi_cnt), 16'h0);
    mem_xfer(0, 24'h000020, 16'h0, 2'h3, q, lat);
    check(q, 16'ha577);
    reg_write(`EMBC_REG_CTRL, 16'h0002);
    mem_xfer(1, 24'h4abc12, 16'h5599, 2'h3, q, lat);
    check({15'h0, ale_first}, 16'h0);
    check({p7_seen, p9_seen}, 16'h4abc);
    check({8'h0, p9_wr}, 16'h0);
    check(16'(hi_cnt), 16'h0);
    mem_xfer(0, 24'h4abc12, 16'h0, 2'h3, q, lat);
    check(q, 16'h0099);
    reg_write(`EMBC_REG_CTRL, 16'h0000);
    mem_xfer(1, 24'h80c3d4, 16'h0066, 2'h3, q, lat);
    check({p7_seen, p9_seen}, 16'hd4c3);
    check(16'(wr_len), 16'h3);
    mem_xfer(0, 24'h80c3d4, 16'h0, 2'h3, q, lat);
    check(q, 16'h0066);
    reg_write(`EMBC_REG_CTRL, 16'h0800);
    mem_xfer(0, 24'h80c3d4, 16'h0, 2'h3, q, lat);
    r = lat;
    mem_xfer(0, 24'h80c3d4, 16'h0, 2'h3, q, lat);
    check(q, 16'h0066);
    check(16'(r - lat), 16'h1);
    check(16'(rd_len), 16'h6);
    reg_write(`EMBC_REG_CTRL, 16'h000f);
    mem_xfer(1, 24'hc00040, 16'h1234, 2'h2, q, lat);
    check({15'h0, hi_cnt != 0}, 16'h1);
    check(16'(lo_cnt), 16'h0);
    check({15'h0, we != 0}, 16'h1);
    reg_write(`EMBC_REG_CTRL, 16'h0057);
    stall <= 1;
    fork
      begin
        repeat (30) @(posedge sys_clk);
        stall <= 0;
      end
    join_none
    mem_xfer(0, 24'hc00000, 16'h0, 2'h3, q, lat);
    check({15'h0, lat > 20}, 16'h1);
    check({15'h0, adv != 0}, 16'h1);
    check({15'h0, tgl > 2}, 16'h1);
    reg_write(`EMBC_REG_CTRL, 16'h0017);
    // Let the stopped bus clock settle before counting edges
    repeat (3) @(posedge sys_clk);
    mem_xfer(0, 24'hc00000, 16'h0, 2'h3, q, lat);
    check(16'(tgl), 16'h0);
    check(16'(multi), 16'h0);
    check(16'(clash), 16'h0);
    close_out();
  end
endmodule
